// *** verilog/hmpc_defs.svh ***
// constants of the halt mode power controller
`ifndef HMPC_DEFS_SVH
`define HMPC_DEFS_SVH

// register indices on the plain register port
`define HMPC_REG_CTRL       4'h0
`define HMPC_REG_STATUS     4'h1

// control register fields
`define HMPC_CTRL_OIE       0
`define HMPC_CTRL_DLY_LONG  1
`define HMPC_CTRL_WDG_OPT   2

// control register reset values
`define HMPC_RST_OIE        1'b0
`define HMPC_RST_DLY_LONG   1'b0
`define HMPC_RST_WDG_OPT    1'b0

// status register fields
`define HMPC_STAT_STATE_LSB 0
`define HMPC_STAT_PW_BUSY   3
`define HMPC_STAT_MASK_LSB  4

// interrupt mask level values
`define HMPC_MASK_RESET     2'b11
`define HMPC_MASK_HALT      2'b10

// wake stabilize delay in cpu cycles, and reference clocks per cpu cycle
`define HMPC_DLY_SHORT_TCPU 256
`define HMPC_DLY_LONG_TCPU  4096
`define HMPC_CPU_PER_REF    1
`define HMPC_DLY_SHORT_CYC  (`HMPC_DLY_SHORT_TCPU * `HMPC_CPU_PER_REF)
`define HMPC_DLY_LONG_CYC   (`HMPC_DLY_LONG_TCPU * `HMPC_CPU_PER_REF)

`endif

// *** verilog/hmpc_pkg.sv ***
// types of the halt mode power controller
package hmpc_pkg;

    typedef enum logic [2:0]
    {
        HMPC_RUN   = 3'b000,
        HMPC_AHALT = 3'b001,
        HMPC_HALT  = 3'b010,
        HMPC_STAB  = 3'b011,
        HMPC_RHALT = 3'b100
    } hmpc_state_e;

    typedef logic [12:0] hmpc_cnt_t;

endpackage

// *** verilog/hmpc_halt_ctrl.sv ***
// halt and active-halt power controller with wake logic
// What this block does
// RULE_01: halt with oscillator irq enable enters active-halt
// RULE_02: halt with enable clear enters full halt
// RULE_03: active-halt wakes on rtc, listed irq, reset
// RULE_04: irq wake from active-halt: no stabilize wait
// RULE_05: halt entry forces mask level to 10
// RULE_06: pending wake irq at entry wakes at once
// RULE_07: active-halt keeps only oscillator and rtc clocked
// RULE_08: enable set: halt with watchdog gives no reset
// RULE_09: software keeps enable set during post-wake delay
// RULE_10: early enable clear: full halt for remaining delay
// RULE_11: full halt wakes on reset or listed irq
// RULE_12: full halt wake restarts oscillator, waits delay
// RULE_13: full halt stops oscillator, cpu and peripherals
// RULE_14: watchdog halt option allows watchdog reset on halt
// RULE_15: service pushes mask, sets priority, pop restores
// RULE_16: software avoids halt opcode byte in constants
// RULE_17: software may clear pending flags before halting
// RULE_18: wake sources synchronized before stabilize count
`timescale 1ns/1ns
`include "hmpc_defs.svh"

module hmpc_halt_ctrl
    import hmpc_pkg::*;
#(
    parameter int N_EXT = 4
)
(
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    // register port
    input  wire logic [3:0]       addr_i,
    input  wire logic [7:0]       wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [7:0]       rdata_o,
    // cpu core
    input  wire logic             halt_exec_i,
    input  wire logic [1:0]       irq_prio_i,
    input  wire logic             iret_i,
    output logic      [1:0]       cc_mask_o,
    output logic      [1:0]       stacked_mask_o,
    output logic                  svc_o,
    output logic                  reset_fetch_o,
    // wake sources
    input  wire logic             rtc_irq_i,
    input  wire logic [N_EXT-1:0] ext_irq_i,
    input  wire logic             rst_wake_i,
    // watchdog
    input  wire logic             wdg_active_i,
    output logic                  wdg_reset_o,
    // clock gates
    output logic                  osc_run_o,
    output logic                  rtc_clk_en_o,
    output logic                  cpu_clk_en_o,
    output logic                  periph_clk_en_o
);

    if (N_EXT < 1 || N_EXT > 16)
    begin
        $error("hmpc_halt_ctrl: N_EXT out of range");
    end

    localparam hmpc_cnt_t DLY_SHORT = hmpc_cnt_t'(`HMPC_DLY_SHORT_CYC);
    localparam hmpc_cnt_t DLY_LONG  = hmpc_cnt_t'(`HMPC_DLY_LONG_CYC);

    // control bits
    logic              osc_irq_enable;
    logic              dly_long;
    logic              watchdog_halt_option;

    // state
    hmpc_state_e       state;
    hmpc_state_e       next_state;
    hmpc_cnt_t         stab_cnt;
    hmpc_cnt_t         pw_cnt;
    logic              stab_is_rst;
    logic              next_stab_is_rst;
    logic [1:0]        cc_mask;
    logic [1:0]        saved_mask;

    // wake synchronizers: first stage read only by the second
    logic [N_EXT+1:0]  wake_meta;
    logic [N_EXT+1:0]  wake_sync;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            wake_meta <= '0;
            wake_sync <= '0;
        end
        else
        begin
            wake_meta <= {rst_wake_i, rtc_irq_i, ext_irq_i}; // RULE_18
            wake_sync <= wake_meta;                          // RULE_18
        end
    end

    function automatic logic is_halted(input hmpc_state_e s);
        return (s == HMPC_AHALT) || (s == HMPC_HALT) || (s == HMPC_RHALT);
    endfunction

    // wake decode
    wire       ext_any   = |wake_sync[N_EXT-1:0];
    wire       rtc_s     = wake_sync[N_EXT];
    wire       rst_s     = wake_sync[N_EXT+1];
    wire       ah_wake   = rtc_s | ext_any;                          // RULE_03
    wire       h_wake    = ext_any;                                  // RULE_11
    wire       halt_pend = osc_irq_enable ? ah_wake : h_wake;
    wire       run_st    = (state == HMPC_RUN);
    wire       wdg_trip  = wdg_active_i & watchdog_halt_option
                           & ~osc_irq_enable;                        // RULE_08 RULE_14
    wire       halt_go   = run_st & halt_exec_i & ~wdg_trip;
    wire       halt_in   = halt_go & ~halt_pend;
    wire       pend_svc  = halt_go & halt_pend;                      // RULE_06
    wire       ah_irq    = (state == HMPC_AHALT) & ~rst_s & ah_wake; // RULE_04
    wire       stab_done = (state == HMPC_STAB) & (stab_cnt == '0);
    wire       early_clr = run_st & ~osc_irq_enable & (pw_cnt != '0)
                           & ~halt_exec_i;                           // RULE_10
    wire       to_stab   = (next_state == HMPC_STAB) && (state != HMPC_STAB);
    wire       svc_now   = pend_svc | ah_irq | (stab_done & ~stab_is_rst);   // RULE_04 RULE_06
    hmpc_cnt_t dly_cyc;
    assign dly_cyc = dly_long ? DLY_LONG : DLY_SHORT;

    // next state
    always_comb
    begin
        next_state       = state;
        next_stab_is_rst = stab_is_rst;
        unique case (state)
            HMPC_RUN:
            begin
                if (halt_in)
                    next_state = osc_irq_enable ? HMPC_AHALT : HMPC_HALT; // RULE_01 RULE_02
                else if (early_clr)
                    next_state = HMPC_RHALT;                              // RULE_10
            end
            HMPC_AHALT:
            begin
                if (rst_s)
                begin
                    next_state       = HMPC_STAB;
                    next_stab_is_rst = 1'b1;
                end
                else if (ah_wake)
                    next_state = HMPC_RUN;                                // RULE_04
            end
            HMPC_HALT:
            begin
                if (rst_s || h_wake)
                begin
                    next_state       = HMPC_STAB;                         // RULE_12
                    next_stab_is_rst = rst_s;
                end
            end
            HMPC_STAB:
            begin
                if (stab_cnt == '0)
                    next_state = HMPC_RUN;                                // RULE_12
            end
            HMPC_RHALT:
            begin
                if (pw_cnt == '0)
                    next_state = HMPC_RUN;                                // RULE_10
            end
            default:
                next_state = HMPC_RUN;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state       <= HMPC_RUN;
            stab_is_rst <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            stab_is_rst <= next_stab_is_rst;
        end
    end

    // stabilize counter: loaded on the way in, exits after dly_cyc cycles
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            stab_cnt <= '0;
        else if (to_stab)
            stab_cnt <= dly_cyc - hmpc_cnt_t'(1); // RULE_12
        else if (stab_cnt != '0)
            stab_cnt <= stab_cnt - hmpc_cnt_t'(1);
    end

    // post-wake delay after an interrupt exit of active-halt
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            pw_cnt <= '0;
        else if (ah_irq)
            pw_cnt <= dly_cyc;                // RULE_09
        else if (pw_cnt != '0)
            pw_cnt <= pw_cnt - hmpc_cnt_t'(1);
    end

    // cpu handshakes
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            svc_o         <= 1'b0;
            reset_fetch_o <= 1'b0;
            wdg_reset_o   <= 1'b0;
        end
        else
        begin
            svc_o         <= svc_now;                                        // RULE_04 RULE_06
            reset_fetch_o <= stab_done & stab_is_rst;                        // RULE_12
            wdg_reset_o   <= run_st & halt_exec_i & wdg_trip;                // RULE_14
        end
    end

    // interrupt mask level, stacked on service and restored on return
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            cc_mask    <= `HMPC_MASK_RESET;
            saved_mask <= `HMPC_MASK_RESET;
        end
        else if (svc_now)
        begin
            saved_mask <= halt_go ? `HMPC_MASK_HALT : cc_mask; // RULE_15
            cc_mask    <= irq_prio_i;                          // RULE_15
        end
        else if (halt_in)
            cc_mask    <= `HMPC_MASK_HALT;                     // RULE_05
        else if (iret_i)
            cc_mask    <= saved_mask;                          // RULE_15
    end

    assign cc_mask_o      = cc_mask;
    assign stacked_mask_o = saved_mask;

    // clock gating from the state
    // the rtc counter runs off the oscillator, so it stops with it
    wire   full_stop       = is_halted(state) && (state != HMPC_AHALT);
    assign osc_run_o       = ~full_stop;                                    // RULE_13
    assign rtc_clk_en_o    = ~full_stop;                                    // RULE_07
    assign cpu_clk_en_o    = (state == HMPC_RUN);                           // RULE_07 RULE_13
    assign periph_clk_en_o = (state == HMPC_RUN);                           // RULE_07 RULE_13

    // register port
    wire       sel_ctrl = (addr_i == `HMPC_REG_CTRL);
    wire       sel_stat = (addr_i == `HMPC_REG_STATUS);
    wire [7:0] ctrl_rd  = {5'h00, watchdog_halt_option, dly_long, osc_irq_enable};
    wire [7:0] stat_rd  = {2'h0, cc_mask, (pw_cnt != '0), state};

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            osc_irq_enable       <= `HMPC_RST_OIE;
            dly_long             <= `HMPC_RST_DLY_LONG;
            watchdog_halt_option <= `HMPC_RST_WDG_OPT;
        end
        else if (wr_i && sel_ctrl)
        begin
            osc_irq_enable       <= wdata_i[`HMPC_CTRL_OIE];
            dly_long             <= wdata_i[`HMPC_CTRL_DLY_LONG];
            watchdog_halt_option <= wdata_i[`HMPC_CTRL_WDG_OPT];
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= sel_ctrl ? ctrl_rd : (sel_stat ? stat_rd : 8'h00);
        else
            rdata_o <= 8'h00;
    end

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_halt_req;
        run_st && halt_exec_i && !wdg_trip && !halt_pend;
    endsequence

    sequence s_enter_stab;
        (state != HMPC_STAB) ##1 (state == HMPC_STAB);
    endsequence

    enter_active_halt_a: assert property (s_halt_req ##0 osc_irq_enable // RULE_01
        |=> state == HMPC_AHALT) else $error("no active-halt entry");

    enter_full_halt_a: assert property (s_halt_req ##0 !osc_irq_enable // RULE_02
        |=> state == HMPC_HALT) else $error("no full halt entry");

    ah_wake_src_a: assert property (state == HMPC_AHALT && !ah_wake && !rst_s // RULE_03
        |=> state == HMPC_AHALT) else $error("active-halt left without cause");

    ah_irq_fast_a: assert property (ah_irq // RULE_04
        |=> svc_o && state == HMPC_RUN) else $error("slow active-halt irq wake");

    halt_mask_a: assert property (s_halt_req // RULE_05
        |=> cc_mask_o == 2'h2) else $error("mask not forced on halt");

    pend_wake_a: assert property (run_st && halt_exec_i && !wdg_trip && halt_pend // RULE_06
        |=> state == HMPC_RUN && svc_o) else $error("pending wake ignored");

    ah_gating_a: assert property (state == HMPC_AHALT // RULE_07
        |-> osc_run_o && rtc_clk_en_o && !periph_clk_en_o && !cpu_clk_en_o)
        else $error("active-halt gating wrong");

    wdg_quiet_a: assert property (run_st && halt_exec_i && osc_irq_enable // RULE_08
        |=> !wdg_reset_o) else $error("watchdog reset with enable set");

    early_clear_a: assert property (early_clr // RULE_10
        |=> state == HMPC_RHALT && !osc_run_o && pw_cnt == $past(pw_cnt) - hmpc_cnt_t'(1))
        else $error("early clear not halted");

    full_halt_rtc_a: assert property (state == HMPC_HALT && !ext_any && !rst_s // RULE_11
        |=> state == HMPC_HALT) else $error("full halt left without cause");

    stab_load_a: assert property (s_enter_stab // RULE_12
        |-> stab_cnt == dly_cyc - hmpc_cnt_t'(1) && osc_run_o)
        else $error("stabilize count wrong");

    stab_exit_a: assert property ($fell(state == HMPC_STAB) // RULE_12
        |-> $past(stab_cnt) == '0 && (svc_o || reset_fetch_o))
        else $error("stabilize ended early");

    full_halt_stop_a: assert property (state == HMPC_HALT // RULE_13
        |-> !osc_run_o && !cpu_clk_en_o && !periph_clk_en_o)
        else $error("full halt clocks running");

    wdg_trip_a: assert property (run_st && halt_exec_i && wdg_trip // RULE_14
        |=> wdg_reset_o && state == HMPC_RUN) else $error("watchdog halt reset missing");

    mask_push_a: assert property (svc_now && !halt_go && !iret_i // RULE_15
        |=> cc_mask_o == $past(irq_prio_i) && stacked_mask_o == $past(cc_mask))
        else $error("mask not stacked");

    sync_path_a: assert property (rst_wake_i ##1 rst_wake_i // RULE_18
        |=> wake_sync[N_EXT+1]) else $error("wake sync latency wrong");

endmodule

// *** bench/hmpc_cpu_model.sv ***
// cpu core stand-in: halts on request and returns from each service
`timescale 1ns/1ns

module hmpc_cpu_model
#(
    parameter logic [1:0] PRIO = 2'b01
)
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // bench and controller side
    input  wire logic       halt_req_i,
    input  wire logic       svc_i,
    output logic            halt_exec_o,
    output logic [1:0]      irq_prio_o,
    output logic            iret_o
);
    logic [2:0] isr_cnt;

    assign irq_prio_o = PRIO;

    // halt only on an explicit request, never from a stray data byte
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            halt_exec_o <= 1'b0;
            isr_cnt     <= 3'h0;
            iret_o      <= 1'b0;
        end
        else
        begin
            halt_exec_o <= halt_req_i;
            iret_o      <= (isr_cnt == 3'h1);
            if (svc_i)
                isr_cnt <= 3'h4;
            else if (isr_cnt != 3'h0)
                isr_cnt <= isr_cnt - 3'h1;
        end
    end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the halt mode power controller
`timescale 1ns/1ns

module testbench;
    logic       ref_clk_i, rst_i, wr_i, rd_i, halt_req, halt_exec_i, iret_i;
    logic [3:0] addr_i, ext_irq_i;
    logic [7:0] wdata_i, rdata_o, d;
    logic [1:0] irq_prio_i, cc_mask_o, stacked_mask_o;
    logic       svc_o, reset_fetch_o, rtc_irq_i, rst_wake_i, wdg_active_i;
    logic       wdg_reset_o, osc_run_o, rtc_clk_en_o, cpu_clk_en_o, periph_clk_en_o;
    int         n_errors, compares, n;

    hmpc_halt_ctrl #(.N_EXT(4)) DUT (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .halt_exec_i, .irq_prio_i, .iret_i, .cc_mask_o,
        .stacked_mask_o, .svc_o, .reset_fetch_o, .rtc_irq_i, .ext_irq_i, .rst_wake_i,
        .wdg_active_i, .wdg_reset_o, .osc_run_o, .rtc_clk_en_o, .cpu_clk_en_o,
        .periph_clk_en_o);
    hmpc_cpu_model #(.PRIO(2'b01)) cpu (.ref_clk_i, .rst_i, .halt_req_i(halt_req),
        .svc_i(svc_o), .halt_exec_o(halt_exec_i), .irq_prio_o(irq_prio_i),
        .iret_o(iret_i));

    always #5 ref_clk_i = ~ref_clk_i;

    task automatic complete_run();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // ends one step after the edge that takes the halt
    task automatic do_halt();
        @(posedge ref_clk_i);
        halt_req <= 1'b1;
        @(posedge ref_clk_i);
        halt_req <= 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask

    // bounded wait for a service or reset-vector pulse
    task automatic wait_wake();
        n = 0;
        while (!(svc_o | reset_fetch_o) && n < 5000)
        begin
            @(posedge ref_clk_i);
            #1 n++;
        end
        if (n >= 5000)
        begin
            n_errors++;
            complete_run();
        end
    endtask

    function automatic logic [3:0] gates();
        return {osc_run_o, rtc_clk_en_o, cpu_clk_en_o, periph_clk_en_o};
    endfunction

    task automatic t_regs();
        reg_rd(4'h0);
        check(d, 8'h00);
        reg_rd(4'h1);
        check(d, 8'h30);
        reg_wr(4'h1, 8'hff);
        reg_wr(4'h7, 8'hff);
        reg_rd(4'h1);
        check(d, 8'h30);
        reg_rd(4'h7);
        check(d, 8'h00);
        reg_rd(4'h0);
        check(d, 8'h00);
        check(gates(), 4'hf);
    endtask

    task automatic t_ahalt();
        reg_wr(4'h0, 8'h01);
        do_halt();
        check(gates(), 4'hc);
        check(cc_mask_o, 2'b10);
        reg_rd(4'h1);
        check(d & 8'h37, 8'h21);
        @(posedge ref_clk_i);
        rtc_irq_i <= 1'b1;
        wait_wake();
        check(svc_o, 1'b1);
        check(n <= 6, 1'b1);
        check({cc_mask_o, stacked_mask_o}, 4'b0110);
        @(posedge ref_clk_i);
        rtc_irq_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        #1 check(cc_mask_o, 2'b10);
        // software clears the enable too early on purpose
        reg_wr(4'h0, 8'h00);
        reg_rd(4'h1);
        check(d & 8'h07, 8'h04);
        check(osc_run_o, 1'b0);
        n = 0;
        while (osc_run_o !== 1'b1 && n < 300)
        begin
            @(posedge ref_clk_i);
            #1 n++;
        end
        if (n >= 300)
        begin
            n_errors++;
            complete_run();
        end
        check(n < 256, 1'b1);
        repeat (2) @(posedge ref_clk_i);
        #1 check(gates(), 4'hf);
    endtask

    task automatic t_halt_ext();
        repeat (300) @(posedge ref_clk_i);
        reg_wr(4'h0, 8'h00);
        do_halt();
        check(gates(), 4'h0);
        reg_rd(4'h1);
        check(d & 8'h37, 8'h22);
        @(posedge ref_clk_i);
        rtc_irq_i <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        #1 check(gates(), 4'h0);
        @(posedge ref_clk_i);
        rtc_irq_i <= 1'b0;
        ext_irq_i <= 4'h4;
        wait_wake();
        check(svc_o, 1'b1);
        check(n >= 256 && n <= 264, 1'b1);
        @(posedge ref_clk_i);
        ext_irq_i <= 4'h0;
    endtask

    task automatic t_pending();
        reg_wr(4'h0, 8'h01);
        // pending flags cleared except the wake source itself
        ext_irq_i <= 4'h1;
        do_halt();
        wait_wake();
        check(n <= 3, 1'b1);
        check(gates(), 4'hf);
        @(posedge ref_clk_i);
        ext_irq_i <= 4'h0;
    endtask

    task automatic t_wdg();
        wdg_active_i <= 1'b1;
        reg_wr(4'h0, 8'h04);
        do_halt();
        check({wdg_reset_o, gates()}, 5'h1f);
        reg_wr(4'h0, 8'h05);
        do_halt();
        check({wdg_reset_o, gates()}, 5'h0c);
        @(posedge ref_clk_i);
        rtc_irq_i <= 1'b1;
        wait_wake();
        check(svc_o, 1'b1);
        @(posedge ref_clk_i);
        rtc_irq_i    <= 1'b0;
        wdg_active_i <= 1'b0;
    endtask

    task automatic t_reset_wake();
        repeat (300) @(posedge ref_clk_i);
        reg_wr(4'h0, 8'h02);
        do_halt();
        @(posedge ref_clk_i);
        rst_wake_i <= 1'b1;
        wait_wake();
        check(reset_fetch_o, 1'b1);
        check(n >= 4096 && n <= 4104, 1'b1);
        @(posedge ref_clk_i);
        rst_wake_i <= 1'b0;
        // a reset wake from active-halt still takes the short delay
        reg_wr(4'h0, 8'h01);
        do_halt();
        check(gates(), 4'hc);
        @(posedge ref_clk_i);
        rst_wake_i <= 1'b1;
        wait_wake();
        check(reset_fetch_o, 1'b1);
        check(n >= 256 && n <= 264, 1'b1);
        @(posedge ref_clk_i);
        rst_wake_i <= 1'b0;
    endtask

    initial
    begin
        ref_clk_i    = 1'b0;
        rst_i        = 1'b1;
        {wr_i, rd_i, halt_req, rtc_irq_i, rst_wake_i, wdg_active_i} = 6'h00;
        addr_i       = 4'h0;
        ext_irq_i    = 4'h0;
        wdata_i      = 8'h00;
        n_errors     = 0;
        compares     = 0;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_ahalt();
        t_halt_ext();
        t_pending();
        t_wdg();
        t_reset_wake();
        complete_run();
    end
endmodule
